// file: core/emrpi_pkg.sv
// Purpose: shared constants for the PHY-end model of the MII/RMII link
// Assumes: one 100 MHz system clock; the link clocks are derived from it
// Notes: the receive FIFO word carries a nibble, an error flag and a frame-end flag
package emrpi_pkg;

  // system clock
  localparam int CLK_NS = 10;

  // link clock periods in ns, as the PHY produces them
  localparam int MII_FAST_PERIOD_NS = 40;   // 25 MHz, 100 Mbit/s
  localparam int MII_SLOW_PERIOD_NS = 400;  // 2.5 MHz, 10 Mbit/s
  localparam int RMII_PERIOD_NS = 20;       // 50 MHz shared reference

  // half periods in system cycles, never below one cycle
  localparam int HALF_FAST_INT = MII_FAST_PERIOD_NS / (2 * CLK_NS);
  localparam int HALF_SLOW_INT = MII_SLOW_PERIOD_NS / (2 * CLK_NS);
  localparam int HALF_RMII_INT = RMII_PERIOD_NS / (2 * CLK_NS);
  localparam logic [4:0] HALF_FAST = 5'(HALF_FAST_INT < 1 ? 1 : HALF_FAST_INT);
  localparam logic [4:0] HALF_SLOW = 5'(HALF_SLOW_INT < 1 ? 1 : HALF_SLOW_INT);
  localparam logic [4:0] HALF_RMII = 5'(HALF_RMII_INT < 1 ? 1 : HALF_RMII_INT);

  // receive FIFO word layout
  localparam int RXW_WIDTH = 6;
  localparam int RXW_DEPTH = 16;
  localparam int RXW_NIB_LSB = 0;
  localparam int RXW_ER_BIT = 4;
  localparam int RXW_LAST_BIT = 5;

  // management clock range codes seen on the far side; 0100..0111 are reserved
  localparam logic [3:0] MDC_SEL_DIV42 = 4'h0;
  localparam logic [3:0] MDC_SEL_DIV64 = 4'h1;
  localparam logic [3:0] MDC_SEL_DIV26 = 4'h2;
  localparam logic [3:0] MDC_SEL_DIV16 = 4'h3;
  localparam logic [3:0] MDC_SEL_RSV_LO = 4'h4;
  localparam logic [3:0] MDC_SEL_RSV_HI = 4'h7;

  // receive drive states
  typedef enum logic [1:0] {
    EMRPI_RX_IDLE = 2'b00,
    EMRPI_RX_DATA = 2'b01,
    EMRPI_RX_HI = 2'b10
  } emrpi_rx_state_t;

endpackage

// file: core/emrpi_fifo.sv
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: full and empty come from an occupancy count, so they are exact
module emrpi_fifo
  import emrpi_pkg::*;
#(
  parameter int WIDTH = RXW_WIDTH,
  parameter int DEPTH = RXW_DEPTH
)(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // handshakes: full refuses the writer, empty hides the reader
  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_ptr];

  // storage, no reset needed on data
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

  chk_fifo_no_overrun: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (count == (AW+1)'(DEPTH)) |-> !push)
    else $error("fifo written while full");

endmodule // emrpi_fifo

// file: core/emrpi_phy_end.sv
// Purpose: PHY end of an MII/RMII link, driving a MAC through its pins
// Assumes: 100 MHz i_clk; link clocks are made here by one divider and driven out
// Notes: MAC pin inputs pass two flops; mode strap is caught at reset release
module emrpi_phy_end
  import emrpi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_rmii_sel,
  input wire logic i_speed_100,
  input wire logic i_full_duplex,
  input wire logic i_col_force,
  input wire logic i_rx_valid,
  output logic o_rx_ready,
  input wire logic [3:0] i_rx_nib,
  input wire logic i_rx_err,
  input wire logic i_rx_last,
  output logic [3:0] o_tx_nib,
  output logic o_tx_valid,
  output logic o_tx_start,
  output logic o_tx_end,
  output logic o_rmii_mode,
  output logic o_tx_clk,
  output logic o_rx_clk,
  output logic o_ref_clk,
  input wire logic i_tx_en,
  input wire logic [3:0] i_txd,
  output logic [3:0] o_rxd,
  output logic o_rx_dv,
  output logic o_rx_er,
  output logic o_crs,
  output logic o_col,
  output logic o_crs_dv
);

  logic strap_done;
  logic rmii;
  logic [4:0] half;
  logic [4:0] div_cnt;
  logic link_clk;
  logic wrap;
  logic rise_en;
  logic fall_en;
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic tx_en_s;
  logic [3:0] txd_s;
  logic tx_en_prev;
  logic dibit_hi;
  logic [1:0] dibit_lo;
  logic tx_seen;
  emrpi_rx_state_t rx_state;
  logic [RXW_WIDTH-1:0] cur;
  logic f_valid;
  logic f_pop;
  logic [RXW_WIDTH-1:0] f_word;
  logic ends_now;
  logic half_dup;

  // mode strap is caught on the first clock after reset, then frozen
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      strap_done <= 1'b0;
      rmii <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      rmii <= i_rmii_sel;
    end
  end

  assign o_rmii_mode = rmii;

  // half period picked from mode and speed
  always_comb
  begin
    if (rmii)
      half = HALF_RMII;
    else if (i_speed_100)
      half = HALF_FAST;
    else
      half = HALF_SLOW;
  end

  // link clock divider; the system clock stands in for the PHY's own reference
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      div_cnt <= '0;
      link_clk <= 1'b0;
    end
    else if (wrap)
    begin
      div_cnt <= '0;
      link_clk <= !link_clk;
    end
    else
    begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // >= keeps the divider safe when speed changes to a shorter half period
  assign wrap = (div_cnt >= half - 5'h01);
  assign rise_en = wrap && !link_clk;
  assign fall_en = wrap && link_clk;
  assign o_tx_clk = link_clk && !rmii;
  assign o_rx_clk = link_clk && !rmii;
  assign o_ref_clk = link_clk && rmii;

  // two-flop synchroniser for the MAC transmit pins
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {i_tx_en, i_txd};
      sync2 <= sync1;
    end
  end

  assign tx_en_s = sync2[4];
  assign txd_s = sync2[3:0];

  // transmit capture at each link rising edge; a lone trailing dibit is dropped
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_tx_nib <= '0;
      o_tx_valid <= 1'b0;
      o_tx_start <= 1'b0;
      o_tx_end <= 1'b0;
      tx_en_prev <= 1'b0;
      dibit_hi <= 1'b0;
      dibit_lo <= '0;
      tx_seen <= 1'b0;
    end
    else
    begin
      o_tx_valid <= 1'b0;
      o_tx_start <= 1'b0;
      o_tx_end <= 1'b0;
      if (rise_en)
      begin
        tx_en_prev <= tx_en_s;
        if (!tx_en_s)
        begin
          dibit_hi <= 1'b0;
          tx_seen <= 1'b0;
          o_tx_end <= tx_en_prev;
        end
        else if (!rmii)
        begin
          o_tx_nib <= txd_s;
          o_tx_valid <= 1'b1;
          o_tx_start <= !tx_en_prev;
        end
        else if (!dibit_hi)
        begin
          dibit_lo <= txd_s[1:0];
          dibit_hi <= 1'b1;
        end
        else
        begin
          o_tx_nib <= {txd_s[1:0], dibit_lo};
          o_tx_valid <= 1'b1;
          // rmii start marks the first complete nibble, not the first dibit
          o_tx_start <= !tx_seen;
          tx_seen <= 1'b1;
          dibit_hi <= 1'b0;
        end
      end
    end
  end

  // receive words wait here; the user side is stalled when it fills
  emrpi_fifo #(
    .WIDTH(RXW_WIDTH),
    .DEPTH(RXW_DEPTH)
  ) u_rx_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_rx_valid),
    .o_in_ready(o_rx_ready),
    .i_in_data({i_rx_last, i_rx_err, i_rx_nib}),
    .o_out_valid(f_valid),
    .i_out_ready(f_pop),
    .o_out_data(f_word)
  );

  // a frame ends one link cycle after its last word went out
  assign ends_now = (rx_state == EMRPI_RX_DATA) && cur[RXW_LAST_BIT];
  assign f_pop = fall_en && f_valid && (rx_state != EMRPI_RX_HI) && !ends_now;

  // receive drive; outputs change on the falling link edge so the MAC samples mid-bit
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_state <= EMRPI_RX_IDLE;
      cur <= '0;
      o_rxd <= '0;
      o_rx_dv <= 1'b0;
      o_rx_er <= 1'b0;
    end
    else if (fall_en)
    begin
      case (rx_state)
        EMRPI_RX_HI:
        begin
          o_rxd <= {2'b00, cur[RXW_NIB_LSB+3 -: 2]};
          rx_state <= EMRPI_RX_DATA;
        end
        EMRPI_RX_IDLE, EMRPI_RX_DATA:
        begin
          if (ends_now)
          begin
            o_rx_dv <= 1'b0;
            o_rx_er <= 1'b0;
            o_rxd <= '0;
            rx_state <= EMRPI_RX_IDLE;
          end
          else if (f_valid)
          begin
            cur <= f_word;
            o_rx_dv <= 1'b1;
            o_rx_er <= f_word[RXW_ER_BIT];
            o_rxd <= rmii ? {2'b00, f_word[RXW_NIB_LSB+1 -: 2]} : f_word[RXW_NIB_LSB+3 -: 4];
            rx_state <= rmii ? EMRPI_RX_HI : EMRPI_RX_DATA;
          end
          else if (rx_state == EMRPI_RX_DATA)
          begin
            // underrun mid-frame: flag it and close the frame next cycle
            o_rx_er <= 1'b1;
            cur[RXW_LAST_BIT] <= 1'b1;
          end
        end
        default:
        begin
          rx_state <= EMRPI_RX_IDLE;
        end
      endcase
    end
  end

  // carrier and collision only exist in half duplex
  assign half_dup = !i_full_duplex;
  assign o_col = half_dup && i_col_force;
  assign o_crs = half_dup && (o_rx_dv || tx_en_s || i_col_force);
  assign o_crs_dv = rmii && (o_rx_dv || o_crs);

  chk_rmii_ref_rate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rmii && $rose(o_ref_clk) |=> $fell(o_ref_clk))
    else $error("rmii reference clock not one cycle high");

  chk_fast_clk_rate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !rmii && i_speed_100 && $past(i_speed_100) && $rose(o_tx_clk)
    |=> o_tx_clk ##1 !o_tx_clk ##1 !o_tx_clk)
    else $error("fast mii clock not 40 ns");

  chk_tx_idle_ignored: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rise_en && !tx_en_s |=> !o_tx_valid)
    else $error("transmit data taken while enable low");

  chk_tx_nibble_taken: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !rmii && rise_en && tx_en_s |=> o_tx_valid && (o_tx_nib == $past(txd_s)))
    else $error("mii nibble not captured");

  chk_rx_dv_ends: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(o_rx_dv) |-> $past(ends_now) && $past(fall_en))
    else $error("data valid dropped outside frame end");

  chk_crs_busy: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_full_duplex && (o_rx_dv || o_col) |-> o_crs)
    else $error("carrier low while medium busy");

  chk_col_full_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_full_duplex |-> !o_col && !o_crs)
    else $error("collision or carrier in full duplex");

  chk_rmii_high_pair: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fall_en && rx_state == EMRPI_RX_HI |=> o_rxd[1:0] == $past(cur[3:2]) && o_rx_dv)
    else $error("upper dibit not sent second");

  chk_rx_err_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    f_pop && f_word[RXW_ER_BIT] |=> o_rx_er [*2])
    else $error("receive error not shown");

  chk_strap_frozen: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    strap_done |=> $stable(rmii))
    else $error("interface mode changed out of reset");

  cov_mii_frame: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    !rmii && $fell(o_rx_dv));
  cov_rmii_frame: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    rmii && $fell(o_rx_dv));
  cov_tx_frame: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_tx_start ##[1:400] o_tx_end);
  cov_fifo_full: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_rx_ready);

endmodule // emrpi_phy_end

// file: bench/emrpi_mac_model.sv
// Purpose: MAC-side partner that works the PHY end through its link pins
// Assumes: link clocks come from the PHY end and are sampled with i_clk
// Notes: pins move at the falling i_clk just after a link rise
module emrpi_mac_model
  import emrpi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_rmii,
  input wire logic i_tx_clk,
  input wire logic i_rx_clk,
  input wire logic i_ref_clk,
  output logic o_tx_en,
  output logic [3:0] o_txd,
  input wire logic [3:0] i_rxd,
  input wire logic i_rx_dv,
  input wire logic i_rx_er,
  input wire logic i_crs_dv,
  input wire logic i_crs,
  input wire logic i_col,
  output logic o_crs_s,
  output logic o_col_s
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] txq[$];
  logic [4:0] rxq[$];
  logic tx_d, rx_d, hi, rx_hi;
  logic [3:0] cur;
  logic [1:0] rx_lo, crs_m, col_m;
  wire tx_lc = i_rmii ? i_ref_clk : i_tx_clk;
  wire rx_lc = i_rmii ? i_ref_clk : i_rx_clk;
  wire rx_ok = i_rmii ? i_crs_dv : i_rx_dv;
  initial
  begin
    o_tx_en = 1'h0;
    o_txd = 4'h0;
  end
  // edge history of both link clocks
  always @(negedge i_clk)
  begin
    tx_d <= tx_lc;
    rx_d <= rx_lc;
  end
  // transmit: one nibble, or one dibit in rmii, per link period
  always @(negedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_tx_en <= 1'h0;
      hi <= 1'h0;
    end
    else if (tx_lc && !tx_d)
    begin
      if (hi)
      begin
        o_txd <= {~o_txd[3:2], cur[3:2]};
        hi <= 1'h0;
      end
      else if (txq.size() > 0)
      begin
        cur = txq.pop_front();
        o_tx_en <= 1'h1;
        o_txd <= i_rmii ? {~o_txd[3:2], cur[1:0]} : cur;
        hi <= i_rmii;
      end
      else
      begin
        // idle lines keep moving so a stale value cannot pass as data
        o_tx_en <= 1'h0;
        o_txd <= ~o_txd;
      end
    end
  end
  // receive: sample at the link rise, half a period after the pins moved
  always @(negedge i_clk)
  begin
    if (!rx_ok)
      rx_hi <= 1'h0;
    else if (rx_lc && !rx_d)
    begin
      if (!i_rmii)
        rxq.push_back({i_rx_er, i_rxd});
      else if (rx_hi)
        rxq.push_back({i_rx_er, i_rxd[1:0], rx_lo});
      rx_lo <= i_rxd[1:0];
      rx_hi <= i_rmii && !rx_hi;
    end
  end
  // two flops before use: carrier and collision arrive unsynchronised
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      crs_m <= 2'h0;
      col_m <= 2'h0;
    end
    else
    begin
      crs_m <= {crs_m[0], i_crs};
      col_m <= {col_m[0], i_col};
    end
  end
  assign o_crs_s = crs_m[1];
  assign o_col_s = col_m[1];
endmodule // emrpi_mac_model

// file: bench/testbench.sv
// Purpose: self-checking bench for the PHY end of the MII/RMII link
// Assumes: 100 MHz clock; the bench moves inputs on the falling edge
// Notes: the MAC model owns the link pins; the bench owns the user side
module testbench
  import emrpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic rmii_sel = 1'h0;
  logic speed_100 = 1'h1;
  logic full_duplex = 1'h1;
  logic col_force = 1'h0;
  logic rx_valid = 1'h0;
  logic [3:0] rx_nib = 4'h0;
  logic rx_err = 1'h0;
  logic rx_last = 1'h0;
  logic rx_ready, tx_valid, tx_start, tx_end, rmii_mode, tx_clk, rx_clk, ref_clk;
  logic rx_dv, rx_er, crs, col, crs_dv, tx_en, crs_s, col_s;
  logic [3:0] tx_nib, txd, rxd;
  logic [3:0] txgot[$];
  int miscompares = 0;
  int cmp_count = 0;
  int starts = 0;
  int ends = 0;
  int start_at = 0;
  always #5 clk = ~clk;
  emrpi_phy_end uut (.i_clk(clk), .i_rst_n(rst_n), .i_rmii_sel(rmii_sel),
    .i_speed_100(speed_100), .i_full_duplex(full_duplex), .i_col_force(col_force),
    .i_rx_valid(rx_valid), .o_rx_ready(rx_ready), .i_rx_nib(rx_nib), .i_rx_err(rx_err),
    .i_rx_last(rx_last), .o_tx_nib(tx_nib), .o_tx_valid(tx_valid), .o_tx_start(tx_start),
    .o_tx_end(tx_end), .o_rmii_mode(rmii_mode), .o_tx_clk(tx_clk), .o_rx_clk(rx_clk),
    .o_ref_clk(ref_clk), .i_tx_en(tx_en), .i_txd(txd), .o_rxd(rxd), .o_rx_dv(rx_dv),
    .o_rx_er(rx_er), .o_crs(crs), .o_col(col), .o_crs_dv(crs_dv));
  emrpi_mac_model mac (.i_clk(clk), .i_rst_n(rst_n), .i_rmii(rmii_mode), .i_tx_clk(tx_clk),
    .i_rx_clk(rx_clk), .i_ref_clk(ref_clk), .o_tx_en(tx_en), .o_txd(txd), .i_rxd(rxd),
    .i_rx_dv(rx_dv), .i_rx_er(rx_er), .i_crs_dv(crs_dv), .i_crs(crs), .i_col(col),
    .o_crs_s(crs_s), .o_col_s(col_s));
  // collect what the PHY end hands over on its user side
  always @(negedge clk)
  begin
    if (tx_start === 1'h1)
    begin
      starts++;
      start_at = txgot.size();
    end
    if (tx_valid === 1'h1)
      txgot.push_back(tx_nib);
    if (tx_end === 1'h1)
      ends++;
  end
  task automatic print_verdict();
    $display("mismatches %0d, comparisons %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'h1)
    begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic halt(input string msg);
    chk(1'h0, msg);
    print_verdict();
  endtask
  function automatic logic lc(input int w);
    return (w == 0) ? tx_clk : (w == 1) ? rx_clk : ref_clk;
  endfunction
  // length of one high phase of a link clock, in system cycles
  task automatic meas(input int w, input int exp);
    int n;
    int h;
    n = 0;
    h = 0;
    while (lc(w) !== 1'h0 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    while (lc(w) !== 1'h1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    while (lc(w) === 1'h1 && n < 200)
    begin
      @(negedge clk);
      n++;
      h++;
    end
    if (n >= 200)
      halt("link clock stuck");
    chk(h == exp, "link clock half period");
  endtask
  task automatic reset_to(input logic rmii);
    rst_n = 1'h0;
    rmii_sel = rmii;
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    repeat (4) @(negedge clk);
    chk(rmii_mode === rmii, "latched mode");
  endtask
  task automatic wait_n(input int w, input int n);
    int k;
    k = 0;
    while ((w == 0 ? txgot.size() : mac.rxq.size()) < n && k < 4000)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 4000)
      halt("wait ran out");
  endtask
  // leaves valid up at a falling edge: the caller pushes again or drops it
  task automatic push(input logic [3:0] nib, input logic err, input logic last);
    int n;
    rx_valid = 1'h1;
    rx_nib = nib;
    rx_err = err;
    rx_last = last;
    n = 0;
    while (rx_ready !== 1'h1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 200)
      halt("receive buffer never ready");
    @(negedge clk);
  endtask
  task automatic run_tx(input logic [3:0] f[$]);
    txgot.delete();
    starts = 0;
    ends = 0;
    foreach (f[i]) mac.txq.push_back(f[i]);
    wait_n(0, f.size());
    repeat (200) @(negedge clk);
    chk(txgot.size() == f.size(), "extra nibbles while enable low");
    foreach (f[i]) chk(txgot[i] === f[i], "transmit nibble");
    chk(starts == 1 && start_at == 0, "frame start pulse");
    chk(ends == 1, "frame end pulse");
  endtask
  task automatic run_rx(input logic [3:0] f[$]);
    mac.rxq.delete();
    foreach (f[i]) push(f[i], 1'h0, i == f.size() - 1);
    rx_valid = 1'h0;
    wait_n(1, f.size());
    repeat (20) @(negedge clk);
    chk(mac.rxq.size() == f.size(), "receive nibble count");
    foreach (f[i]) chk(mac.rxq[i] === {1'h0, f[i]}, "receive nibble");
    chk(rx_dv === 1'h0, "data valid left high");
  endtask
  task automatic sc_clocks();
    meas(0, HALF_FAST);
    meas(1, HALF_FAST);
    speed_100 = 1'h0;
    repeat (50) @(negedge clk);
    meas(0, HALF_SLOW);
    meas(1, HALF_SLOW);
    speed_100 = 1'h1;
    repeat (50) @(negedge clk);
  endtask
  task automatic sc_rx_err();
    logic seen;
    mac.rxq.delete();
    push(4'h9, 1'h1, 1'h1);
    rx_valid = 1'h0;
    wait_n(1, 1);
    chk(mac.rxq[0] === 5'h19, "flagged word lost its error");
    seen = 1'h0;
    push(4'h6, 1'h0, 1'h0);
    rx_valid = 1'h0;
    repeat (40)
    begin
      @(negedge clk);
      if (rx_er === 1'h1)
        seen = 1'h1;
    end
    chk(seen, "underrun not flagged");
    chk(rx_dv === 1'h0, "frame not closed after underrun");
  endtask
  // slow link drains one word per 40 cycles, so the buffer fills first
  task automatic sc_fifo();
    int cnt;
    // switch speed only in a low phase so no fast high phase gets stretched
    meas(0, HALF_FAST);
    speed_100 = 1'h0;
    mac.rxq.delete();
    cnt = 0;
    while (rx_ready === 1'h1 && cnt < 40)
    begin
      push(4'(cnt), 1'h0, 1'h0);
      cnt++;
    end
    chk(cnt >= RXW_DEPTH && cnt <= RXW_DEPTH + 1, "buffer depth");
    push(4'hf, 1'h0, 1'h1);
    rx_valid = 1'h0;
    wait_n(1, cnt + 1);
    for (int i = 0; i < cnt; i++) chk(mac.rxq[i] === {1'h0, 4'(i)}, "drain order");
    chk(mac.rxq[cnt] === 5'h0f, "last word");
    speed_100 = 1'h1;
    repeat (50) @(negedge clk);
  endtask
  task automatic sc_crs_col();
    full_duplex = 1'h0;
    col_force = 1'h1;
    repeat (4) @(negedge clk);
    chk(col === 1'h1 && crs === 1'h1, "collision or carrier missing");
    chk(col_s === 1'h1, "collision not seen after sync");
    col_force = 1'h0;
    txgot.delete();
    mac.txq = '{4'h5, 4'h5, 4'h5, 4'hd};
    wait_n(0, 1);
    chk(crs === 1'h1 && col === 1'h0, "carrier while sending");
    wait_n(0, 4);
    repeat (100) @(negedge clk);
    chk(crs === 1'h0, "carrier on idle medium");
    full_duplex = 1'h1;
    col_force = 1'h1;
    repeat (4) @(negedge clk);
    chk(col === 1'h0 && crs === 1'h0, "full duplex shows carrier");
    col_force = 1'h0;
  endtask
  task automatic sc_rmii();
    int n;
    reset_to(1'h1);
    rmii_sel = 1'h0;
    meas(2, HALF_RMII);
    n = 0;
    repeat (20)
    begin
      @(negedge clk);
      if (tx_clk !== 1'h0 || rx_clk !== 1'h0)
        n++;
    end
    chk(n == 0 && rmii_mode === 1'h1, "mii clocks or mode in rmii");
    run_tx('{4'h5, 4'hd, 4'h6, 4'h9});
    run_rx('{4'ha, 4'h5, 4'h3});
  endtask
  initial
  begin
    reset_to(1'h0);
    sc_clocks();
    run_tx('{4'h5, 4'h5, 4'hd, 4'ha, 4'h3});
    run_rx('{4'h3, 4'hc, 4'h7});
    sc_rx_err();
    sc_fifo();
    sc_crs_col();
    sc_rmii();
    print_verdict();
  end
endmodule // testbench
